// ### pkg/periodic_timer_pkg.sv
// Shared constants for the two-channel periodic timer
// Assumes one 200 MHz system clock and a 32-bit APB register bus
`default_nettype none

package periodic_timer_pkg;

    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DIV_W = 9;
    localparam int NUM_TICKS = 4;

    // Register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_RUN = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_CSR0 = 8'h02;
    localparam logic [ADDR_W-1:0] IDX_CNT0 = 8'h04;
    localparam logic [ADDR_W-1:0] IDX_COR0 = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_CSR1 = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_CNT1 = 8'h0A;
    localparam logic [ADDR_W-1:0] IDX_COR1 = 8'h0C;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h0E;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h10;

    // Field positions
    localparam int RUN0_BIT = 0;
    localparam int RUN1_BIT = 1;
    localparam int FLAG_BIT = 7;
    localparam int IRQEN_BIT = 6;
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 1;

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COR_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DIV_W-1:0] DIV_RST = 9'h000;
    localparam logic [DIV_W-1:0] DIV_ONE = 9'h001;

    // Prescaler masks for divide by 8, 32, 128 and 512
    localparam logic [DIV_W-1:0] DIV_MASK [NUM_TICKS] = '{9'h007, 9'h01F, 9'h07F, 9'h1FF};

    typedef enum logic [1:0] {
        TICK_DIV8 = 2'h0,
        TICK_DIV32 = 2'h1,
        TICK_DIV128 = 2'h2,
        TICK_DIV512 = 2'h3
    } tick_sel_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction

endpackage

`default_nettype wire

// ### src/tick_prescaler.sv
// Free-running prescaler giving four divided tick enables
// Assumes the system clock; standby restarts the division
`default_nettype none

module tick_prescaler
    import periodic_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby,
    output logic [NUM_TICKS-1:0] tick
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Next divider value
    always_comb begin
        s_d = s_q;
        s_d.div = s_q.div + DIV_ONE;
        if (standby) begin
            s_d.div = DIV_RST;
        end
    end

    // Divider register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{div: DIV_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // One-cycle enables when the low bits wrap
    always_comb begin
        for (int i = 0; i < NUM_TICKS; i++) begin
            tick[i] = (s_q.div & DIV_MASK[i]) == DIV_MASK[i];
        end
    end

endmodule

`default_nettype wire

// ### src/period_channel.sv
// One compare-match channel: counter, match and sticky flag
// Assumes tick is a one-cycle enable and writes come at the APB access edge
`default_nettype none

module period_channel
    import periodic_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby,
    input wire logic tick,
    input wire logic run,
    input wire logic [CNT_W-1:0] period_constant,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [CNT_W-1:0] wdata,
    input wire logic sw_clr,
    input wire logic xfer_clr,
    output logic [CNT_W-1:0] count,
    output logic match_flag,
    output logic hit
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic flag;
    } chan_state_t;

    chan_state_t s_q;
    chan_state_t s_d;

    // Match fires on the tick that leaves the matching value
    assign hit = tick & run & (s_q.cnt == period_constant);

    ////////////////////////////////////////////////////////////////////////////////
    // Counter and flag next state
    always_comb begin
        s_d = s_q;
        if (hit) begin
            s_d.cnt = CNT_RST;
        end else if (wr_lo | wr_hi) begin
            // Unwritten byte keeps its old value, increment dropped
            if (wr_lo) begin
                s_d.cnt[7:0] = wdata[7:0];
            end
            if (wr_hi) begin
                s_d.cnt[15:8] = wdata[15:8];
            end
        end else if (tick & run) begin
            s_d.cnt = s_q.cnt + CNT_ONE;
        end
        // Clear first so a same-cycle match still sets
        if (sw_clr | xfer_clr) begin
            s_d.flag = 1'b0;
        end
        if (hit) begin
            s_d.flag = 1'b1;
        end
        if (standby) begin
            s_d = '{cnt: CNT_RST, flag: 1'b0};
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{cnt: CNT_RST, flag: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
    assign match_flag = s_q.flag;

endmodule

`default_nettype wire

// ### src/periodic_timer.sv
// Two-channel periodic compare-match timer with APB register access
// Assumes one system clock, zero-wait APB master and a synchronous
// standby level from the power controller; manual reset is not wired in
`default_nettype none

module periodic_timer
    import periodic_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire logic [1:0] xfer_clr,
    output logic [1:0] match_irq,
    output logic [1:0] xfer_req,
    output logic [1:0] xfer_pick,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0] run;
        logic [1:0] irq_en;
        logic [1:0] sel0;
        logic [1:0] sel1;
        logic [CNT_W-1:0] cor0;
        logic [CNT_W-1:0] cor1;
        logic [1:0] armed;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
    } regs_state_t;

    localparam regs_state_t REGS_RST = '{
        run: 2'h0,
        irq_en: 2'h0,
        sel0: TICK_DIV8,
        sel1: TICK_DIV8,
        cor0: COR_RST,
        cor1: COR_RST,
        armed: 2'h0,
        irq_stat: 2'h0,
        irq_mask: 2'h0,
        rdata: 32'h0000_0000
    };

    regs_state_t s_q;
    regs_state_t s_d;

    logic [NUM_TICKS-1:0] tick;
    logic [1:0] hit;
    logic [1:0] flag;
    logic [CNT_W-1:0] count0;
    logic [CNT_W-1:0] count1;
    logic [1:0] sw_clr;
    logic [1:0] cnt_wr_lo;
    logic [1:0] cnt_wr_hi;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic aligned;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address matches a register index
    function automatic logic hit_reg(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] idx);
        return addr == byte_addr(idx);
    endfunction

    // Pick the enable named by a select code
    function automatic logic pick_tick(input logic [1:0] sel,
                                       input logic [NUM_TICKS-1:0] ticks);
        logic t;
        t = 1'b0;
        case (sel)
            TICK_DIV8: t = ticks[0];
            TICK_DIV32: t = ticks[1];
            TICK_DIV128: t = ticks[2];
            TICK_DIV512: t = ticks[3];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Control/status read image of a channel
    function automatic logic [31:0] csr_image(input logic f,
                                              input logic en,
                                              input logic [1:0] sel);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[FLAG_BIT] = f;
        v[IRQEN_BIT] = en;
        v[SEL_MSB:SEL_LSB] = sel;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Tick source and channels

    tick_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .standby(standby),
        .tick(tick)
    );

    period_channel u_chan0 (
        .pclk(pclk),
        .presetn(presetn),
        .standby(standby),
        .tick(pick_tick(s_q.sel0, tick)),
        .run(s_q.run[RUN0_BIT]),
        .period_constant(s_q.cor0),
        .wr_lo(cnt_wr_lo[0]),
        .wr_hi(cnt_wr_hi[0]),
        .wdata(pwdata[CNT_W-1:0]),
        .sw_clr(sw_clr[0]),
        .xfer_clr(xfer_clr[0]),
        .count(count0),
        .match_flag(flag[0]),
        .hit(hit[0])
    );

    period_channel u_chan1 (
        .pclk(pclk),
        .presetn(presetn),
        .standby(standby),
        .tick(pick_tick(s_q.sel1, tick)),
        .run(s_q.run[RUN1_BIT]),
        .period_constant(s_q.cor1),
        .wr_lo(cnt_wr_lo[1]),
        .wr_hi(cnt_wr_hi[1]),
        .wdata(pwdata[CNT_W-1:0]),
        .sw_clr(sw_clr[1]),
        .xfer_clr(xfer_clr[1]),
        .count(count1),
        .match_flag(flag[1]),
        .hit(hit[1])
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Phases of a transfer
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;

    // Known word addresses only
    assign aligned = paddr[1:0] == 2'b00;
    assign mapped = hit_reg(paddr, IDX_RUN) | hit_reg(paddr, IDX_CSR0)
        | hit_reg(paddr, IDX_CNT0) | hit_reg(paddr, IDX_COR0)
        | hit_reg(paddr, IDX_CSR1) | hit_reg(paddr, IDX_CNT1)
        | hit_reg(paddr, IDX_COR1) | hit_reg(paddr, IDX_IRQ_STAT)
        | hit_reg(paddr, IDX_IRQ_MASK);

    // Zero wait, error on unmapped access
    assign pready = 1'b1;
    assign pslverr = access & ~(mapped & aligned);
    assign prdata = s_q.rdata;

    // Counter byte strobes
    always_comb begin
        cnt_wr_lo[0] = wr & hit_reg(paddr, IDX_CNT0) & pstrb[0];
        cnt_wr_hi[0] = wr & hit_reg(paddr, IDX_CNT0) & pstrb[1];
        cnt_wr_lo[1] = wr & hit_reg(paddr, IDX_CNT1) & pstrb[0];
        cnt_wr_hi[1] = wr & hit_reg(paddr, IDX_CNT1) & pstrb[1];
    end

    // Zero written to flag after it was read as one
    always_comb begin
        sw_clr[0] = wr & hit_reg(paddr, IDX_CSR0) & pstrb[0]
            & s_q.armed[0] & ~pwdata[FLAG_BIT];
        sw_clr[1] = wr & hit_reg(paddr, IDX_CSR1) & pstrb[0]
            & s_q.armed[1] & ~pwdata[FLAG_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register next state

    always_comb begin
        s_d = s_q;

        // Read data captured in the setup phase
        if (setup) begin
            s_d.rdata = 32'h0000_0000;
            if (hit_reg(paddr, IDX_RUN)) begin
                s_d.rdata[1:0] = s_q.run;
            end
            if (hit_reg(paddr, IDX_CSR0)) begin
                s_d.rdata = csr_image(flag[0], s_q.irq_en[0], s_q.sel0);
            end
            if (hit_reg(paddr, IDX_CSR1)) begin
                s_d.rdata = csr_image(flag[1], s_q.irq_en[1], s_q.sel1);
            end
            if (hit_reg(paddr, IDX_CNT0)) begin
                s_d.rdata[CNT_W-1:0] = count0;
            end
            if (hit_reg(paddr, IDX_CNT1)) begin
                s_d.rdata[CNT_W-1:0] = count1;
            end
            if (hit_reg(paddr, IDX_COR0)) begin
                s_d.rdata[CNT_W-1:0] = s_q.cor0;
            end
            if (hit_reg(paddr, IDX_COR1)) begin
                s_d.rdata[CNT_W-1:0] = s_q.cor1;
            end
            if (hit_reg(paddr, IDX_IRQ_STAT)) begin
                s_d.rdata[1:0] = s_q.irq_stat;
            end
            if (hit_reg(paddr, IDX_IRQ_MASK)) begin
                s_d.rdata[1:0] = s_q.irq_mask;
            end
        end

        // Arm the flag clear on a read that returned one
        if (rd && hit_reg(paddr, IDX_CSR0) && s_q.rdata[FLAG_BIT]) begin
            s_d.armed[0] = 1'b1;
        end
        if (rd && hit_reg(paddr, IDX_CSR1) && s_q.rdata[FLAG_BIT]) begin
            s_d.armed[1] = 1'b1;
        end

        // Run bits
        if (wr && hit_reg(paddr, IDX_RUN) && pstrb[0]) begin
            s_d.run = pwdata[1:0];
        end

        // Channel control; any flag write consumes the arming
        if (wr && hit_reg(paddr, IDX_CSR0) && pstrb[0]) begin
            s_d.irq_en[0] = pwdata[IRQEN_BIT];
            s_d.sel0 = pwdata[SEL_MSB:SEL_LSB];
            s_d.armed[0] = 1'b0;
        end
        if (wr && hit_reg(paddr, IDX_CSR1) && pstrb[0]) begin
            s_d.irq_en[1] = pwdata[IRQEN_BIT];
            s_d.sel1 = pwdata[SEL_MSB:SEL_LSB];
            s_d.armed[1] = 1'b0;
        end

        // Compare constants, per byte lane
        if (wr && hit_reg(paddr, IDX_COR0)) begin
            if (pstrb[0]) begin
                s_d.cor0[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                s_d.cor0[15:8] = pwdata[15:8];
            end
        end
        if (wr && hit_reg(paddr, IDX_COR1)) begin
            if (pstrb[0]) begin
                s_d.cor1[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                s_d.cor1[15:8] = pwdata[15:8];
            end
        end

        // Summary status: write one to clear, new match wins
        if (wr && hit_reg(paddr, IDX_IRQ_STAT) && pstrb[0]) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[1:0];
        end
        s_d.irq_stat = s_d.irq_stat | hit;

        // Summary mask
        if (wr && hit_reg(paddr, IDX_IRQ_MASK) && pstrb[0]) begin
            s_d.irq_mask = pwdata[1:0];
        end

        // Standby restores every control to its reset value
        if (standby) begin
            s_d = REGS_RST;
        end
    end

    // Register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt and transfer requests

    // Per-channel request from flag and enable
    assign match_irq = flag & s_q.irq_en;

    // Same requests start the transfer controller
    assign xfer_req = match_irq;

    // Channel 0 always served first
    always_comb begin
        xfer_pick = 2'b00;
        if (match_irq[0]) begin
            xfer_pick = 2'b01;
        end else if (match_irq[1]) begin
            xfer_pick = 2'b10;
        end
    end

    // Summary interrupt level
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule

`default_nettype wire

// ### dv/periodic_timer_chk.sv
// Port-level checks of the periodic timer
// Assumes binding into periodic_timer; one clock domain
`default_nettype none

module periodic_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic standby,
    input wire logic [1:0] xfer_clr,
    input wire logic [1:0] match_irq,
    input wire logic [1:0] xfer_req,
    input wire logic [1:0] xfer_pick,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase_q;
    logic [2:0] phase_d;
    logic tick8;
    logic bus_wr;

    // Mirror of the divide-by-8 phase
    always_comb begin
        phase_d = standby ? 3'h0 : phase_q + 3'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_d;
        end
    end
    assign tick8 = (phase_q == 3'h7);
    assign bus_wr = psel && penable && pwrite;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////
    a_pick_fixed: assert property (xfer_pick == {xfer_req[1] && !xfer_req[0], xfer_req[0]})
        else $error("transfer pick not channel 0 first");
    a_req_mirror: assert property (xfer_req == match_irq)
        else $error("transfer request differs from interrupt");
    a_reset_quiet: assert property ($rose(presetn) |-> match_irq == 2'h0 && prdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_stby_quiet: assert property (standby |=> match_irq == 2'h0 && irq == 1'b0)
        else $error("outputs not cleared by standby");
    a_fall0_cause: assert property ($fell(match_irq[0]) |->
        $past(xfer_clr[0]) || $past(bus_wr) || $past(standby))
        else $error("channel 0 request fell without a clear");
    a_fall1_cause: assert property ($fell(match_irq[1]) |->
        $past(xfer_clr[1]) || $past(bus_wr) || $past(standby))
        else $error("channel 1 request fell without a clear");
    a_rise0_tick: assert property ($rose(match_irq[0]) |-> $past(tick8) || $past(bus_wr))
        else $error("channel 0 match off a tick edge");
    a_rise1_tick: assert property ($rose(match_irq[1]) |-> $past(tick8) || $past(bus_wr))
        else $error("channel 1 match off a tick edge");

    // Main scenarios reached
    c_match0: cover property ($rose(match_irq[0]));
    c_pick1: cover property (xfer_pick == 2'h2);
    c_refused: cover property (pslverr);
endmodule

`default_nettype wire

// ### dv/xfer_ctl_model.sv
// Transfer controller model: serves the picked channel, then clears it
// Assumes en and lag come from the bench; lag sets a slow reply
`default_nettype none

module xfer_ctl_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [3:0] lag,
    input wire logic [1:0] pick,
    output logic [1:0] clr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    logic [1:0] hold_q;

    // Take the picked request, wait lag cycles, pulse its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
            hold_q <= 2'h0;
            clr <= 2'h0;
        end else begin
            clr <= 2'h0;
            if (hold_q != 2'h0) begin
                if (wait_q == lag) begin
                    clr <= hold_q;
                    hold_q <= 2'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else if (en && pick != 2'h0 && clr == 2'h0) begin
                hold_q <= pick;
                wait_q <= 4'h0;
            end
        end
    end
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// Bench for the periodic timer: register table, periods, contention
// Assumes design, checker and transfer model compiled before it
`default_nettype none

module tb_top
    import periodic_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic w;
        logic [7:0] idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic standby = 1'b0;
    logic model_en = 1'b0;
    logic [3:0] model_lag = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq;
    logic [1:0] xfer_clr, match_irq, xfer_req, xfer_pick;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    row_t rows [14] = '{'{1'b0, IDX_RUN, 32'h0, 32'h0}, '{1'b0, IDX_CSR0, 32'h0, 32'h0},
        '{1'b0, IDX_CNT0, 32'h0, 32'h0}, '{1'b0, IDX_COR0, 32'h0, 32'hFFFF},
        '{1'b0, IDX_CSR1, 32'h0, 32'h0}, '{1'b0, IDX_CNT1, 32'h0, 32'h0},
        '{1'b0, IDX_COR1, 32'h0, 32'hFFFF}, '{1'b0, IDX_IRQ_STAT, 32'h0, 32'h0},
        '{1'b1, IDX_COR1, 32'hFFFF1234, 32'h1234}, '{1'b1, IDX_CSR1, 32'hFFFFFFFF, 32'h43},
        '{1'b1, IDX_CNT0, 32'hFFFF5A5A, 32'h5A5A}, '{1'b1, IDX_RUN, 32'hFFFFFFFF, 32'h3},
        '{1'b1, IDX_RUN, 32'h0, 32'h0}, '{1'b1, 8'h3F, 32'hFFFFFFFF, 32'h0}};

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    periodic_timer periodic_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
        .xfer_clr(xfer_clr), .match_irq(match_irq), .xfer_req(xfer_req),
        .xfer_pick(xfer_pick), .irq(irq));
    xfer_ctl_model xfer_ctl_model_i (.pclk(pclk), .presetn(presetn), .en(model_en),
        .lag(model_lag), .pick(xfer_pick), .clr(xfer_clr));

    ////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic give_up();
        bad_count++;
        $display("Error at %0t: wait ran out", $time);
        conclude();
    endtask
    // One APB transfer; read data lands in rd
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) give_up();
    endtask
    task automatic stby();
        @(posedge pclk);
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
    endtask
    task automatic cfg(input int ch, input logic [15:0] cor, input logic [1:0] sel);
        apb(1'b1, IDX_COR0 + 8'(6 * ch), {16'h0, cor}, 4'hF);
        apb(1'b1, IDX_CSR0 + 8'(6 * ch), {24'h0, 2'h1, 4'h0, sel}, 4'hF);
    endtask
    // Returns one edge after the match edge of channel ch
    task automatic wait_rise(input int ch);
        int n;
        n = 0;
        while (match_irq[ch] !== 1'b0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        while (match_irq[ch] !== 1'b1 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) give_up();
    endtask
    // Counter write landing d+3 edges after the match is seen
    task automatic clash(input int d, input logic [31:0] wd, input logic [3:0] st,
                         input logic [31:0] exp);
        stby();
        cfg(0, 16'h0001, 2'h0);
        apb(1'b1, IDX_RUN, 32'h1, 4'hF);
        wait_rise(0);
        repeat (d) @(posedge pclk);
        apb(1'b1, IDX_CNT0, wd, st);
        apb(1'b0, IDX_CNT0, 32'h0, 4'h0);
        check(rd, exp);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Register table rows
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].idx, rows[i].wd, 4'hF);
            apb(1'b0, rows[i].idx, 32'h0, 4'h0);
            check(rd, rows[i].exp);
        end
        // Period of three ticks for every select on both channels
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                stby();
                model_en <= 1'b1;
                model_lag <= 4'(5 * ch);
                cfg(ch, 16'h0002, 2'(s));
                apb(1'b1, IDX_RUN, 32'(1 << ch), 4'hF);
                wait_rise(ch);
                t0 = cyc;
                wait_rise(ch);
                check(32'(cyc - t0), 32'(3 * (8 << (2 * s))));
                check(32'(match_irq[1 - ch]), 32'h0);
            end
        end
        // Both match at once, then enable, flag clear and summary
        stby();
        model_en <= 1'b0;
        cfg(0, 16'h0001, 2'h0);
        cfg(1, 16'h0001, 2'h0);
        apb(1'b1, IDX_RUN, 32'h3, 4'hF);
        wait_rise(0);
        check(32'(xfer_pick), 32'h1);
        check(32'(match_irq), 32'h3);
        apb(1'b1, IDX_RUN, 32'h0, 4'hF);
        apb(1'b1, IDX_CSR0, 32'h0, 4'hF);
        @(negedge pclk);
        check(32'(xfer_pick), 32'h2);
        apb(1'b1, IDX_CSR0, 32'h40, 4'hF);
        @(negedge pclk);
        check(32'(match_irq[0]), 32'h1);
        apb(1'b0, IDX_CSR0, 32'h0, 4'h0);
        check(rd, 32'hC0);
        apb(1'b1, IDX_CSR0, 32'h40, 4'hF);
        @(negedge pclk);
        check(32'(match_irq[0]), 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 32'h1, 4'hF);
        @(negedge pclk);
        check(32'(irq), 32'h1);
        apb(1'b1, IDX_IRQ_MASK, 32'h0, 4'hF);
        @(negedge pclk);
        check(32'(irq), 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 32'h1, 4'hF);
        apb(1'b1, IDX_IRQ_STAT, 32'h3, 4'hF);
        @(negedge pclk);
        check(32'(irq), 32'h0);
        // Counter writes against a match and an increment
        clash(12, 32'h5555, 4'h3, 32'h0);
        clash(4, 32'h0100, 4'h3, 32'h0100);
        clash(4, 32'hAB00, 4'h2, 32'hAB00);
        // Power-on reset in mid-run restores constants and requests
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_COR0, 32'h0, 4'h0);
        check(rd, 32'hFFFF);
        check(32'(match_irq), 32'h0);
        conclude();
    end
    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge pclk);
        give_up();
    end
endmodule

bind periodic_timer periodic_timer_chk periodic_timer_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
    .standby(standby), .xfer_clr(xfer_clr), .match_irq(match_irq), .xfer_req(xfer_req),
    .xfer_pick(xfer_pick), .irq(irq));

`default_nettype wire
